// [logic/adi_defs.svh]
// constants for the converter digital interface: offsets, fields, resets, sizes
// assumes inclusion by bare name from any file of the block
`ifndef ADI_DEFS_SVH
`define ADI_DEFS_SVH

// sample path sizes
`define ADI_SAMPLE_W 16
`define ADI_PAIRS 8
`define ADI_BUF_DEPTH 2

// synchroniser slots and their reset levels (chip select idles high)
`define ADI_NSYNC 6
`define ADI_SYN_STRAP 0
`define ADI_SYN_ENCP 1
`define ADI_SYN_ENCN 2
`define ADI_SYN_CS 3
`define ADI_SYN_SCK 4
`define ADI_SYN_SDI 5
`define ADI_SYNC_RESET 6'h08

// serial frame: 1 read flag, 7 address bits, 8 data bits, msb first
`define ADI_HALF_LAST 3'h7

// mode register addresses
`define ADI_ADDR_PWR 7'h01
`define ADI_ADDR_CLK 7'h02
`define ADI_ADDR_OUT 7'h03

// mode register fields
`define ADI_PWR_SLEEP 0
`define ADI_CLK_DCS 0
`define ADI_CLK_PH_LSB 1
`define ADI_CLK_PH_MSB 2
`define ADI_OUT_MODE_LSB 0
`define ADI_OUT_MODE_MSB 1
`define ADI_OUT_CUR_LSB 2
`define ADI_OUT_CUR_MSB 4
`define ADI_OUT_TERM 5

// mode register reset values: awake, no clock delay, cmos, nominal current
`define ADI_PWR_RESET 8'h00
`define ADI_CLK_RESET 8'h00
`define ADI_OUT_RESET 8'h00

// lvds drive current code for 3.5 mA, also the nominal setting
`define ADI_CUR_3P5MA 3'h0
`define ADI_PHASE_ZERO 2'h0

`endif

// [logic/adi_pkg.sv]
// types shared by the converter digital interface
// assumes nothing beyond a SystemVerilog compiler
package adi_pkg;
    typedef enum logic [1:0] {
        ADI_OM_CMOS,
        ADI_OM_DDR_CMOS,
        ADI_OM_DDR_LVDS
    } adi_omode_type;

    typedef enum logic [1:0] {
        ADI_SP_HEAD,
        ADI_SP_DATA,
        ADI_SP_DONE
    } adi_spi_state_type;
endpackage

// [logic/adi_pair_buf.sv]
// two-entry sample buffer with valid/ready on both sides
// assumes both sides run on core_clk
`timescale 1ns/1ps
`include "adi_defs.svh"
module adi_pair_buf (
    input wire logic core_clk, // core clock
    input wire logic rstn, // sync reset, low
    input wire logic in_valid, // word offered
    output logic in_ready, // room for a word
    input wire logic [`ADI_SAMPLE_W-1:0] in_data, // word in
    output logic out_valid, // word waiting
    input wire logic out_ready, // drain takes word
    output logic [`ADI_SAMPLE_W-1:0] out_data // oldest word
);
    logic [`ADI_SAMPLE_W-1:0] mem_reg [0:`ADI_BUF_DEPTH-1];
    logic wr_ptr_reg;
    logic rd_ptr_reg;
    logic [1:0] count_reg;
    logic push;
    logic pop;

    // honest flags straight from the occupancy count
    assign in_ready = (count_reg != 2'h2);
    assign out_valid = (count_reg != 2'h0);
    assign push = in_valid & in_ready;
    assign pop = out_valid & out_ready;
    assign out_data = mem_reg[rd_ptr_reg];

    // storage, written only on an accepted word
    always_ff @(posedge core_clk) begin
        if (push) begin
            mem_reg[wr_ptr_reg] <= in_data;
        end
    end

    // pointers and count
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            wr_ptr_reg <= 1'b0;
            rd_ptr_reg <= 1'b0;
            count_reg <= 2'h0;
        end else begin
            if (push) begin
                wr_ptr_reg <= ~wr_ptr_reg;
            end
            if (pop) begin
                rd_ptr_reg <= ~rd_ptr_reg;
            end
            if (push && !pop) begin
                count_reg <= count_reg + 2'h1;
            end else if (pop && !push) begin
                count_reg <= count_reg - 2'h1;
            end
        end
    end
endmodule

// [logic/adi_iface.sv]
// digital control and output formatting of a 16-bit pipelined converter
// assumes pins arrive asynchronously; encode and serial clock are far slower
// than core_clk; sample words come from core logic on core_clk
`timescale 1ns/1ps
`include "adi_defs.svh"
module adi_iface (
    input wire logic core_clk, // core clock, 50 MHz
    input wire logic rstn, // sync reset, low
    input wire logic program_mode_strap, // low serial, high parallel
    input wire logic encode_clock_pos, // encode, positive
    input wire logic encode_clock_neg, // encode, complement
    input wire logic cs_n, // chip select or stabilizer level
    input wire logic sck, // serial clock or output mode level
    input wire logic sdi, // serial data or sleep level
    input wire logic sdo_in, // sdo wire level, unused
    output logic sdo_out, // sdo drive value, always low
    output logic sdo_oe, // sdo pull-down enable
    input wire logic [`ADI_SAMPLE_W-1:0] sample_data, // converted word
    input wire logic sample_valid, // word offered
    output logic sample_ready, // buffer has room
    output logic conv_start, // one pulse per conversion
    output logic [`ADI_SAMPLE_W-1:0] data_pins, // output pin values
    output logic [`ADI_SAMPLE_W-1:0] data_pins_oe, // pin drive enables
    output logic fwd_data_clock_pos, // forwarded clock
    output logic fwd_data_clock_neg, // forwarded clock, inverse
    output adi_pkg::adi_omode_type out_mode, // active output mode
    output logic lvds_enable, // lvds drivers on
    output logic [2:0] lvds_current, // lvds current code
    output logic lvds_term_en, // internal termination on
    output logic dcs_enable, // duty-cycle stabilizer on
    output logic sleep_mode // power-down
);
    import adi_pkg::*;

    logic [`ADI_NSYNC-1:0] pins_raw;
    logic [`ADI_NSYNC-1:0] pin_s;
    logic [`ADI_NSYNC-1:0] pin_d;
    logic [`ADI_NSYNC-1:0] sync_rst;
    logic serial_mode;
    logic enc_lvl;
    logic enc_lvl_d;
    logic enc_rise;
    logic enc_fall;
    logic sck_rise;
    logic sck_fall;
    logic spi_active;
    adi_spi_state_type spi_state_reg;
    logic [2:0] bit_cnt_reg;
    logic [7:0] shift_reg;
    logic [7:0] head_reg;
    logic [7:0] rx_byte;
    logic wr_fire;
    logic [7:0] pwr_reg;
    logic [7:0] clk_reg;
    logic [7:0] out_reg;
    logic [7:0] rd_word;
    logic [7:0] rd_shift_reg;
    logic rd_loaded_reg;
    adi_omode_type omode_next;
    logic dcs_next;
    logic sleep_next;
    logic [2:0] cur_next;
    logic term_next;
    logic [1:0] phase_next;
    adi_omode_type omode_reg;
    logic [1:0] phase_reg;
    logic buf_valid;
    logic [`ADI_SAMPLE_W-1:0] buf_data;
    logic load_evt;
    logic [`ADI_SAMPLE_W-1:0] word_reg;
    logic odd_reg;
    logic fwd_base_reg;
    logic [2:0] dline_reg;
    logic fwd_next;
    logic [`ADI_SAMPLE_W-1:0] pins_next;
    logic [`ADI_SAMPLE_W-1:0] oe_next;

    assign pins_raw = {sdi, sck, cs_n, encode_clock_neg, encode_clock_pos, program_mode_strap};
    assign sync_rst = `ADI_SYNC_RESET;

    // two-flop synchronisers plus a third stage that edge detection reads
    genvar gi;
    generate
        for (gi = 0; gi < `ADI_NSYNC; gi = gi + 1) begin : g_sync
            logic s1_reg;
            logic s2_reg;
            logic s3_reg;
            always_ff @(posedge core_clk) begin
                if (!rstn) begin
                    s1_reg <= sync_rst[gi];
                    s2_reg <= sync_rst[gi];
                    s3_reg <= sync_rst[gi];
                end else begin
                    s1_reg <= pins_raw[gi];
                    s2_reg <= s1_reg;
                    s3_reg <= s2_reg;
                end
            end
            assign pin_s[gi] = s2_reg;
            assign pin_d[gi] = s3_reg;
        end
    endgenerate

    // strap decides the meaning of the three control pins
    assign serial_mode = ~pin_s[`ADI_SYN_STRAP];
    assign enc_lvl = pin_s[`ADI_SYN_ENCP] & ~pin_s[`ADI_SYN_ENCN];
    assign enc_lvl_d = pin_d[`ADI_SYN_ENCP] & ~pin_d[`ADI_SYN_ENCN];
    assign enc_rise = enc_lvl & ~enc_lvl_d;
    assign enc_fall = ~enc_lvl & enc_lvl_d;
    assign sck_rise = pin_s[`ADI_SYN_SCK] & ~pin_d[`ADI_SYN_SCK];
    assign sck_fall = ~pin_s[`ADI_SYN_SCK] & pin_d[`ADI_SYN_SCK];
    // port live only in serial mode with select low
    assign spi_active = serial_mode & ~pin_s[`ADI_SYN_CS];
    assign rx_byte = {shift_reg[6:0], pin_s[`ADI_SYN_SDI]};

    // serial receive, one bit per rising sck
    always_ff @(posedge core_clk) begin
        if (!rstn || !spi_active) begin
            spi_state_reg <= ADI_SP_HEAD;
            bit_cnt_reg <= 3'h0;
            shift_reg <= 8'h00;
            head_reg <= 8'h00;
        end else if (sck_rise) begin
            shift_reg <= rx_byte;
            bit_cnt_reg <= bit_cnt_reg + 3'h1;
            unique case (spi_state_reg)
                ADI_SP_HEAD: begin
                    if (bit_cnt_reg == `ADI_HALF_LAST) begin
                        head_reg <= rx_byte;
                        spi_state_reg <= ADI_SP_DATA;
                    end
                end
                ADI_SP_DATA: begin
                    if (bit_cnt_reg == `ADI_HALF_LAST) begin
                        spi_state_reg <= ADI_SP_DONE;
                    end
                end
                ADI_SP_DONE: begin
                end
            endcase
        end
    end

    // a write frame commits on its last data bit; extra clocks are ignored
    assign wr_fire = spi_active & sck_rise & (spi_state_reg == ADI_SP_DATA) &
        (bit_cnt_reg == `ADI_HALF_LAST) & ~head_reg[7];

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            pwr_reg <= `ADI_PWR_RESET;
            clk_reg <= `ADI_CLK_RESET;
            out_reg <= `ADI_OUT_RESET;
        end else if (wr_fire) begin
            if (head_reg[6:0] == `ADI_ADDR_PWR) begin
                pwr_reg <= rx_byte;
            end
            if (head_reg[6:0] == `ADI_ADDR_CLK) begin
                clk_reg <= rx_byte;
            end
            if (head_reg[6:0] == `ADI_ADDR_OUT) begin
                out_reg <= rx_byte;
            end
        end
    end

    // readback mux, unmapped reads as zero
    always_comb begin
        rd_word = 8'h00;
        if (head_reg[6:0] == `ADI_ADDR_PWR) begin
            rd_word = pwr_reg;
        end else if (head_reg[6:0] == `ADI_ADDR_CLK) begin
            rd_word = clk_reg;
        end else if (head_reg[6:0] == `ADI_ADDR_OUT) begin
            rd_word = out_reg;
        end
    end

    // readback: new bit after each falling sck, pull-down only
    assign sdo_out = 1'b0;
    always_ff @(posedge core_clk) begin
        if (!rstn || !spi_active) begin
            rd_shift_reg <= 8'hFF;
            rd_loaded_reg <= 1'b0;
            sdo_oe <= 1'b0;
        end else if (sck_fall && head_reg[7] && spi_state_reg != ADI_SP_HEAD) begin
            if (!rd_loaded_reg) begin
                sdo_oe <= ~rd_word[7];
                rd_shift_reg <= {rd_word[6:0], 1'b1};
                rd_loaded_reg <= 1'b1;
            end else begin
                sdo_oe <= ~rd_shift_reg[7];
                rd_shift_reg <= {rd_shift_reg[6:0], 1'b1};
            end
        end
    end

    // working configuration from registers or from the parallel levels
    always_comb begin
        omode_next = ADI_OM_CMOS;
        dcs_next = 1'b0;
        sleep_next = 1'b0;
        cur_next = `ADI_CUR_3P5MA;
        term_next = 1'b0;
        phase_next = `ADI_PHASE_ZERO;
        if (serial_mode) begin
            dcs_next = clk_reg[`ADI_CLK_DCS];
            sleep_next = pwr_reg[`ADI_PWR_SLEEP];
            cur_next = out_reg[`ADI_OUT_CUR_MSB:`ADI_OUT_CUR_LSB];
            term_next = out_reg[`ADI_OUT_TERM];
            phase_next = clk_reg[`ADI_CLK_PH_MSB:`ADI_CLK_PH_LSB];
            unique case (out_reg[`ADI_OUT_MODE_MSB:`ADI_OUT_MODE_LSB])
                2'h1: omode_next = ADI_OM_DDR_CMOS;
                2'h2: omode_next = ADI_OM_DDR_LVDS;
                default: omode_next = ADI_OM_CMOS;
            endcase
        end else begin
            dcs_next = pin_s[`ADI_SYN_CS];
            sleep_next = pin_s[`ADI_SYN_SDI];
            // sck picks cmos or lvds, never ddr cmos
            omode_next = pin_s[`ADI_SYN_SCK] ? ADI_OM_DDR_LVDS : ADI_OM_CMOS;
        end
    end

    // configuration outputs held in flops
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            omode_reg <= ADI_OM_CMOS;
            dcs_enable <= 1'b0;
            sleep_mode <= 1'b0;
            lvds_current <= `ADI_CUR_3P5MA;
            lvds_term_en <= 1'b0;
            phase_reg <= `ADI_PHASE_ZERO;
            lvds_enable <= 1'b0;
        end else begin
            omode_reg <= omode_next;
            dcs_enable <= dcs_next;
            sleep_mode <= sleep_next;
            lvds_current <= cur_next;
            lvds_term_en <= term_next;
            phase_reg <= phase_next;
            lvds_enable <= (omode_next == ADI_OM_DDR_LVDS);
        end
    end
    assign out_mode = omode_reg;

    // buffer absorbs words while the output side waits for an encode edge
    adi_pair_buf u_buf (
        .core_clk(core_clk),
        .rstn(rstn),
        .in_valid(sample_valid),
        .in_ready(sample_ready),
        .in_data(sample_data),
        .out_valid(buf_valid),
        .out_ready(load_evt),
        .out_data(buf_data)
    );

    // cmos loads on encode rise, ddr loads on encode fall
    assign load_evt = ~sleep_mode & ((omode_reg == ADI_OM_CMOS) ? enc_rise : enc_fall);

    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            conv_start <= 1'b0;
        end else begin
            conv_start <= enc_rise & ~sleep_mode;
        end
    end

    // held word and ddr half select; empty buffer repeats the last word
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            word_reg <= '0;
            odd_reg <= 1'b0;
        end else begin
            if (load_evt && buf_valid) begin
                word_reg <= buf_data;
            end
            if (load_evt) begin
                odd_reg <= 1'b0;
            end else if (enc_rise && !sleep_mode) begin
                odd_reg <= 1'b1;
            end
        end
    end

    // clock base: cmos falls with data, ddr tracks half select
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            fwd_base_reg <= 1'b0;
            dline_reg <= 3'h0;
        end else begin
            if (!sleep_mode) begin
                fwd_base_reg <= (omode_reg == ADI_OM_CMOS) ? ~enc_lvl : enc_lvl;
            end
            dline_reg <= {dline_reg[1:0], fwd_base_reg};
        end
    end

    // delay tap selection; zero keeps default alignment with data
    always_comb begin
        fwd_next = fwd_base_reg;
        if (phase_reg != `ADI_PHASE_ZERO) begin
            fwd_next = dline_reg[phase_reg - 2'h1];
        end
    end

    // pin mapping, pair k on pin 2k+1, its mate or spare slot on pin 2k
    genvar gk;
    generate
        for (gk = 0; gk < `ADI_PAIRS; gk = gk + 1) begin : g_pair
            logic ddr_bit;
            assign ddr_bit = odd_reg ? word_reg[2*gk+1] : word_reg[2*gk];
            always_comb begin
                pins_next[2*gk] = 1'b0;
                pins_next[2*gk+1] = ddr_bit;
                oe_next[2*gk] = 1'b0;
                oe_next[2*gk+1] = 1'b1;
                unique case (omode_reg)
                    ADI_OM_CMOS: begin
                        pins_next[2*gk] = word_reg[2*gk];
                        pins_next[2*gk+1] = word_reg[2*gk+1];
                        oe_next[2*gk] = 1'b1;
                    end
                    // one bit pin, spare slot undriven
                    ADI_OM_DDR_CMOS: begin
                        pins_next[2*gk] = 1'b0;
                    end
                    ADI_OM_DDR_LVDS: begin
                        pins_next[2*gk] = ~ddr_bit;
                        oe_next[2*gk] = 1'b1;
                    end
                    default: begin
                    end
                endcase
            end
        end
    endgenerate

    // pins and both clock legs registered together
    always_ff @(posedge core_clk) begin
        if (!rstn) begin
            data_pins <= '0;
            data_pins_oe <= '0;
            fwd_data_clock_pos <= 1'b0;
            fwd_data_clock_neg <= 1'b1;
        end else begin
            data_pins <= pins_next;
            data_pins_oe <= oe_next;
            fwd_data_clock_pos <= fwd_next;
            fwd_data_clock_neg <= ~fwd_next;
        end
    end

    chk_clk_inverse: assert property (@(posedge core_clk) disable iff (!rstn)
        fwd_data_clock_neg == !fwd_data_clock_pos)
        else $error("forwarded clock legs not complementary");

    chk_par_dcs_level: assert property (@(posedge core_clk) disable iff (!rstn)
        !serial_mode |=> dcs_enable == $past(pin_s[`ADI_SYN_CS]))
        else $error("stabilizer does not follow chip select level");

    chk_par_sleep_level: assert property (@(posedge core_clk) disable iff (!rstn)
        !serial_mode |=> sleep_mode == $past(pin_s[`ADI_SYN_SDI]))
        else $error("sleep does not follow sdi level");

    chk_par_lvds_sel: assert property (@(posedge core_clk) disable iff (!rstn)
        (!serial_mode && pin_s[`ADI_SYN_SCK]) |=> lvds_enable && lvds_current == `ADI_CUR_3P5MA)
        else $error("sck high did not select lvds at nominal current");

    chk_par_no_ddrcmos: assert property (@(posedge core_clk) disable iff (!rstn)
        !serial_mode |=> omode_reg != ADI_OM_DDR_CMOS)
        else $error("ddr cmos selected in parallel mode");

    chk_conv_pulse: assert property (@(posedge core_clk) disable iff (!rstn)
        (enc_rise && !sleep_mode) |=> conv_start ##1 !conv_start)
        else $error("conversion pulse missing or too long");

    chk_cs_high_idle: assert property (@(posedge core_clk) disable iff (!rstn)
        !spi_active |=> bit_cnt_reg == 3'h0 && spi_state_reg == ADI_SP_HEAD && !sdo_oe)
        else $error("serial port active with chip select high");

    chk_write_commit: assert property (@(posedge core_clk) disable iff (!rstn)
        (wr_fire && head_reg[6:0] == `ADI_ADDR_OUT) |=> out_reg == $past(rx_byte))
        else $error("register write lost");

    chk_cmos_pins_map: assert property (@(posedge core_clk) disable iff (!rstn)
        (omode_reg == ADI_OM_CMOS ##1 omode_reg == ADI_OM_CMOS) |->
        data_pins == $past(word_reg) && data_pins_oe == 16'hFFFF)
        else $error("full-rate pins do not carry the held word");

    chk_ddr_spare_slot: assert property (@(posedge core_clk) disable iff (!rstn)
        omode_reg == ADI_OM_DDR_CMOS |=> data_pins_oe == 16'hAAAA)
        else $error("ddr cmos spare slots driven");
endmodule

// [tb/adi_host.sv]
// host side: serial configuration master and sample receiver
// assumes the bench resolves sdo with its board pull-up
`timescale 1ns/1ps
module adi_host (
    input wire logic core_clk, // core clock
    output logic cs_n, // chip select
    output logic sck, // serial clock
    output logic sdi, // serial data
    input wire logic sdo_wire, // resolved sdo
    input wire logic ddr, // expect ddr words
    input wire logic fwd_clk, // forwarded clock
    input wire logic [15:0] pins // data pins
);
    logic fq = 1'b0;
    logic [15:0] pq;
    logic [15:0] ev;
    logic [15:0] words[$];
    initial begin
        cs_n = 1'b1;
        sck = 1'b0;
        sdi = 1'b0;
    end
    // static levels in parallel mode
    task automatic lv(input logic [2:0] v);
        @(posedge core_clk);
        {cs_n, sck, sdi} <= v;
    endtask
    // frame under select, sdi steady over rise
    task automatic spi(input logic [15:0] f, input int nb, output logic [7:0] rd);
        rd = 8'h00;
        @(posedge core_clk);
        cs_n <= 1'b0;
        for (int i = 15; i > 15 - nb; i--) begin
            sdi <= f[i];
            repeat (4) @(posedge core_clk);
            sck <= 1'b1;
            repeat (4) @(posedge core_clk);
            if (i < 8) rd[i] = sdo_wire;
            sck <= 1'b0;
        end
        repeat (4) @(posedge core_clk);
        cs_n <= 1'b1;
        sdi <= ~sdi; // deselected line shows no stale bit
        repeat (6) @(posedge core_clk);
    endtask
    // pair odd bits of the high phase with even bits of the low phase
    function automatic logic [15:0] zip(input logic [15:0] e, input logic [15:0] o);
        for (int k = 0; k < 8; k++) begin
            zip[2*k] = e[2*k+1];
            zip[2*k+1] = o[2*k+1];
        end
    endfunction
    always @(posedge core_clk) begin
        if (fwd_clk && !fq) begin
            ev <= pq;
            if (!ddr) words.push_back(pq);
        end
        if (!fwd_clk && fq && ddr) words.push_back(zip(ev, pq));
        fq <= fwd_clk;
        pq <= pins;
    end
endmodule

// [tb/tb_top.sv]
// self-checking bench for the converter digital interface
// assumes adi_host on the far side and a pull-up on sdo
`timescale 1ns/1ps
`include "adi_defs.svh"
module tb_top;
    import adi_pkg::*;
    logic core_clk = 1'b0;
    logic rstn = 1'b0;
    logic strap = 1'b0;
    logic encp = 1'b0;
    logic encn = 1'b1;
    logic enc_run = 1'b0;
    logic [3:0] ecnt = 4'h0;
    logic [15:0] sdat = 16'h0000;
    logic svalid = 1'b0;
    logic rx_ddr = 1'b0;
    logic cs_n, sck, sdi, sdo_out, sdo_oe, sready, conv, fwdp, fwdn, lvds_en, term, dcs, slp;
    logic [2:0] cur;
    logic [15:0] pins, pins_oe, e;
    logic [7:0] rd;
    logic [7:0] modes [3] = '{8'h01, 8'h00, 8'h02};
    adi_omode_type omode;
    int miscompares = 0;
    int n_compared = 0;
    int n_enc = 0;
    int n_conv = 0;
    int n_lag = 0;
    int hit;
    wire sdo_wire = sdo_oe ? sdo_out : 1'b1;
    initial forever #10 core_clk = ~core_clk;
    adi_iface u_dut (.core_clk(core_clk), .rstn(rstn), .program_mode_strap(strap),
        .encode_clock_pos(encp), .encode_clock_neg(encn), .cs_n(cs_n), .sck(sck),
        .sdi(sdi), .sdo_in(sdo_wire), .sdo_out(sdo_out), .sdo_oe(sdo_oe),
        .sample_data(sdat), .sample_valid(svalid), .sample_ready(sready),
        .conv_start(conv), .data_pins(pins), .data_pins_oe(pins_oe),
        .fwd_data_clock_pos(fwdp), .fwd_data_clock_neg(fwdn), .out_mode(omode),
        .lvds_enable(lvds_en), .lvds_current(cur), .lvds_term_en(term),
        .dcs_enable(dcs), .sleep_mode(slp));
    adi_host u_host (.core_clk(core_clk), .cs_n(cs_n), .sck(sck), .sdi(sdi),
        .sdo_wire(sdo_wire), .ddr(rx_ddr), .fwd_clk(fwdp), .pins(pins));
    task automatic check(input logic [15:0] got, input logic [15:0] exp);
        n_compared++;
        if (got !== exp) begin
            miscompares++;
            $display("wrong value at %0t: got %h expected %h", $time, got, exp);
        end
    endtask
    task automatic final_report();
        $display("compared %0d, mismatched %0d", n_compared, miscompares);
        if (miscompares == 0 && n_compared > 0)
            $display("ALL TESTS PASSED");
        else
            $display("TESTS FAILED");
        $finish;
    endtask
    task automatic wr(input logic [6:0] a, input logic [7:0] d);
        u_host.spi({1'b0, a, d}, 16, rd);
    endtask
    // offer one word, stall bounded
    task automatic push(input logic [15:0] w);
        @(posedge core_clk);
        svalid <= 1'b1;
        sdat <= w;
        for (int i = 0; i <= 20; i++) begin
            @(posedge core_clk);
            if (sready) break;
            if (i == 20) begin
                miscompares++;
                final_report();
            end
        end
        svalid <= 1'b0;
    endtask
    // encode runs for n periods of 16 core cycles, then settles
    task automatic run(input int n);
        enc_run <= 1'b1;
        repeat (16 * n) @(posedge core_clk);
        enc_run <= 1'b0;
        repeat (8) @(posedge core_clk);
    endtask
    always @(posedge core_clk) begin
        if (enc_run) begin
            ecnt <= ecnt + 4'h1;
            encp <= ecnt[3];
            encn <= ~ecnt[3];
            if (ecnt == 4'h8) n_enc++;
        end
        if (conv) n_conv++;
        // cycles in which the clock lags pair 0 of the pins
        if (pins[1] != fwdp) n_lag++;
    end
    always @(negedge core_clk) begin
        if (rstn) check(16'(fwdn), 16'(!fwdp));
    end
    initial begin
        repeat (3) @(posedge core_clk);
        rstn <= 1'b1;
        repeat (4) @(posedge core_clk);
        check({dcs, slp, term, cur, 6'h0, omode}, 16'h0000);
        $display("reset test done");
        wr(`ADI_ADDR_OUT, 8'h35);
        check({term, cur, omode}, {1'b1, 3'h5, ADI_OM_DDR_CMOS});
        u_host.spi({1'b1, `ADI_ADDR_OUT, 8'h00}, 16, rd);
        check(16'(rd), 16'h0035);
        u_host.spi({1'b1, 7'h10, 8'h00}, 16, rd);
        check(16'(rd), 16'h0000);
        wr(`ADI_ADDR_PWR, 8'h01);
        u_host.spi({1'b0, `ADI_ADDR_PWR, 8'h00}, 12, rd);
        check(16'(slp), 16'h0001);
        n_conv = 0;
        run(4);
        check(16'(n_conv), 16'h0000);
        wr(`ADI_ADDR_PWR, 8'h00);
        wr(`ADI_ADDR_CLK, 8'h01);
        check(16'(dcs), 16'h0001);
        $display("serial test done");
        for (int m = 0; m < 3; m++) begin
            wr(`ADI_ADDR_OUT, modes[m]);
            rx_ddr <= (m != 1);
            push(16'hA5C3 + 16'(m));
            push(16'h5A3C - 16'(m));
            @(negedge core_clk);
            check(16'(sready), 16'h0000);
            u_host.words.delete();
            n_enc = 0;
            n_conv = 0;
            run(8);
            check(16'(n_conv), 16'(n_enc));
            hit = 0;
            foreach (u_host.words[i]) if (u_host.words[i] === 16'hA5C3 + 16'(m)) hit = 1;
            check(16'(hit), 16'h0001);
            check(u_host.words[$], 16'h5A3C - 16'(m));
            check(pins_oe, (m == 0) ? 16'hAAAA : 16'hFFFF);
            if (m == 2) check(16'(pins[0] ^ pins[1]), 16'h0001);
        end
        // clock three cycles late: each of four ddr edges shows three lagging cycles
        wr(`ADI_ADDR_CLK, 8'h07);
        n_lag = 0;
        run(2);
        check(16'(n_lag), 16'h000C);
        $display("sample test done");
        strap <= 1'b1;
        for (int v = 0; v < 8; v++) begin
            u_host.lv(3'(v));
            repeat (6) @(posedge core_clk);
            e = {v[2], v[0], 3'h0, v[1], 8'h0, v[1] ? ADI_OM_DDR_LVDS : ADI_OM_CMOS};
            check({dcs, slp, cur, lvds_en, term, 7'h0, omode}, e);
        end
        $display("parallel test done");
        final_report();
    end
endmodule
